// *** logic/ssq_status_seq.sv ***
// status reporting, interrupt pin, lock pin and init/pulse sequencing
// Functional notes
// RULE1: momentary status bits mirror live conditions
// RULE2: sticky bit set on fault, cleared by 1
// RULE3: clear has no effect while fault persists
// RULE4: per-bit enable masks sticky from interrupt
// RULE5: interrupt pin low while any enabled sticky
// RULE6: input status 1 active, 0 loss
// RULE7: pll lock status 1 locked, 0 unlocked
// RULE8: holdover status 1 not in holdover
// RULE9: vco cal bit 1 until calibration done
// RULE10: reference status depends on selection mode
// RULE11: lock pin high only when both locked
// RULE12: bypassed first pll ignored for lock pin
// RULE13: reset gives defaults, tune mid, outputs off
// RULE14: deterministic delay with no bypass, cascade feedback
// RULE15: divider sync holds outputs low, self-clears
// RULE16: retrain and band cal separate access, self-clear; code starts band cal only when strobed in the same cycle as retrain
// RULE17: clearing tune hold releases control voltage
// RULE18: host enables outputs in separate write
// RULE19: host avoids reserved and high addresses
// RULE20: internal source: each release makes one burst
// RULE21: external source: burst on next trigger edge
// RULE22: host order for divider changes
// RULE23: host order for initial setup
// RULE24: counted mode emits count then stops
// RULE25: sticky set on any faulty cycle
`timescale 1ns/1ps
module ssq_status_seq
  import ssq_pkg::*;
(
  input  wire logic        clk_in,                   // 100 MHz clock
  input  wire logic        rst_b_in,                 // async reset, active low
  input  wire logic [3:0]  input_active_in,          // input clock activity
  input  wire logic        first_pll_lock_in,        // first pll locked
  input  wire logic        second_pll_lock_in,       // second pll locked
  input  wire logic        holdover_in,              // device in holdover
  input  wire logic        vco_cal_done_in,          // vco calibration done
  input  wire logic [1:0]  ref_mode_in,              // selection mode
  input  wire logic [1:0]  selected_input_in,        // currently selected input
  input  wire logic [7:0]  irq_enable_in,            // per-sticky enables
  input  wire logic [7:0]  sticky_clear_in,          // write-1 clear strobes
  input  wire logic        first_pll_bypass_in,      // first pll bypass
  input  wire logic        second_pll_fb_select_in,  // cascaded feedback select
  input  wire logic        div_sync_start_in,        // divider sync set strobe
  input  wire logic        pll_retrain_in,           // retrain set strobe
  input  wire logic        vco_band_cal_start_in,    // band cal set strobe
  input  wire logic        vcxo_tune_hold_in,        // hold tune voltage
  input  wire logic        pulse_source_select_in,   // 0 internal, 1 external
  input  wire logic        pulse_mode_select_in,     // 0 counted, 1 continuous
  input  wire logic        pulse_release_in,         // release set strobe
  input  wire logic [7:0]  pulse_count_value_in,     // pulses per burst
  input  wire logic        ext_pulse_trigger_in,     // external trigger
  input  wire logic        outputs_enable_in,        // output enables
  output logic [3:0]       input0_active_now_out,    // live input status
  output logic             first_pll_locked_now_out, // live first pll lock
  output logic             second_pll_locked_now_out,// live second pll lock
  output logic             not_holdover_now_out,     // live holdover
  output logic             vco_cal_pending_out,      // calibration pending
  output logic [1:0]       selected_input_report_out,// selected input
  output logic             reference_valid_now_out,  // reference valid
  output logic [7:0]       sticky_out,               // latched bits
  output logic             irq_n_pin_out,            // interrupt, active low
  output logic             lock_pin_out,             // combined lock
  output logic             deterministic_out,        // deterministic delay mode
  output logic             div_sync_busy_out,        // sync in progress
  output logic             pll_retrain_out,          // retrain busy
  output logic             vco_band_cal_out,         // band cal busy
  output logic             vcxo_tune_mid_out,        // tune forced mid
  output logic             clock_outputs_en_out,     // clock outputs enabled
  output logic             sysref_outputs_out,       // sysref output level
  output logic             sysref_active_out         // sysref powered
);
  logic [7:0] fault_w;
  logic [7:0] irq_vec_w;
  logic [7:0] sticky_w;
  logic       ref_ok_w;
  logic       sel_active_w;
  logic       any_active_w;
  logic       lock_w;

  assign sel_active_w = input_active_in[selected_input_in];
  assign any_active_w = |input_active_in;
  // reference validity by selection mode
  assign ref_ok_w = (ref_mode_in == SSQ_MODE_MANUAL || ref_mode_in == SSQ_MODE_SHORT)
                    ? sel_active_w
                    : (ref_mode_in == SSQ_MODE_AUTOHO)
                      ? (any_active_w & ~(holdover_in & ~sel_active_w))
                      : any_active_w; // RULE10

  assign fault_w[SSQ_BIT_IN0 +: SSQ_NUM_INPUTS] = ~input_active_in; // RULE6
  assign fault_w[SSQ_BIT_PLL1] = ~first_pll_lock_in;                 // RULE7
  assign fault_w[SSQ_BIT_PLL2] = ~second_pll_lock_in;                // RULE7
  assign fault_w[SSQ_BIT_HOLD] = holdover_in;                         // RULE8
  assign fault_w[SSQ_BIT_REF]  = ~ref_ok_w;

  for (genvar i = 0; i < SSQ_NUM_STICKY; i++) begin : g_sticky
    ssq_sticky_bit u_bit (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .fault_in   (fault_w[i]),
      .clear_in   (sticky_clear_in[i]),
      .enable_in  (irq_enable_in[i]),
      .sticky_out (sticky_w[i]),
      .irq_out    (irq_vec_w[i])
    );
  end

  // first pll lock ignored while bypassed
  assign lock_w = second_pll_lock_in & (first_pll_lock_in | first_pll_bypass_in); // RULE11 RULE12

  // registered status outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input0_active_now_out     <= 4'h0;
      first_pll_locked_now_out  <= 1'b0;
      second_pll_locked_now_out <= 1'b0;
      not_holdover_now_out      <= 1'b0;
      vco_cal_pending_out       <= 1'b1;
      selected_input_report_out <= 2'h0;
      reference_valid_now_out   <= 1'b0;
      sticky_out                <= SSQ_STICKY_RST;
      irq_n_pin_out             <= 1'b1;
      lock_pin_out              <= 1'b0;
      deterministic_out         <= 1'b0;
    end else begin
      input0_active_now_out     <= input_active_in;      // RULE1 RULE6
      first_pll_locked_now_out  <= first_pll_lock_in;    // RULE7
      second_pll_locked_now_out <= second_pll_lock_in;   // RULE7
      not_holdover_now_out      <= ~holdover_in;         // RULE8
      vco_cal_pending_out       <= ~vco_cal_done_in;     // RULE9
      selected_input_report_out <= selected_input_in;
      reference_valid_now_out   <= ref_ok_w;             // RULE10
      sticky_out                <= sticky_w;
      irq_n_pin_out             <= ~(|irq_vec_w);        // RULE5
      lock_pin_out              <= lock_w;               // RULE11
      deterministic_out         <= ~first_pll_bypass_in & second_pll_fb_select_in; // RULE14
    end
  end

  // divider sync and retrain self-clearing timers
  logic [3:0] sync_cnt_q;
  logic [3:0] sync_cnt_d;
  logic [3:0] retrain_cnt_q;
  logic [3:0] retrain_cnt_d;
  logic       band_cal_q;
  logic       sync_busy_w;

  assign sync_busy_w   = sync_cnt_q != 4'h0;
  assign sync_cnt_d    = div_sync_start_in ? SSQ_INIT_CYC_W
                       : sync_busy_w ? sync_cnt_q - 4'h1 : 4'h0; // RULE15
  // retrain strobe is ignored while sync is busy
  assign retrain_cnt_d = (pll_retrain_in && !sync_busy_w) ? SSQ_RETRAIN_CYC
                       : (retrain_cnt_q != 4'h0) ? retrain_cnt_q - 4'h1 : 4'h0; // RULE16

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_cnt_q    <= 4'h0;
      retrain_cnt_q <= 4'h0;
      band_cal_q    <= 1'b0;
    end else begin
      sync_cnt_q    <= sync_cnt_d;
      retrain_cnt_q <= retrain_cnt_d;
      if (pll_retrain_in && vco_band_cal_start_in && !sync_busy_w) begin
        band_cal_q <= 1'b1;
      end else if (retrain_cnt_q == 4'h1) begin
        band_cal_q <= 1'b0;  // RULE16
      end
    end
  end

  // output and tune control
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_sync_busy_out    <= 1'b0;
      pll_retrain_out      <= 1'b0;
      vco_band_cal_out     <= 1'b0;
      vcxo_tune_mid_out    <= 1'b1;  // RULE13
      clock_outputs_en_out <= 1'b0;  // RULE13
    end else begin
      div_sync_busy_out    <= sync_cnt_d != 4'h0;
      pll_retrain_out      <= retrain_cnt_d != 4'h0;
      vco_band_cal_out     <= band_cal_q;
      vcxo_tune_mid_out    <= vcxo_tune_hold_in;  // RULE17
      clock_outputs_en_out <= outputs_enable_in & (sync_cnt_d == 4'h0); // RULE15
    end
  end

  // sysref pulse generator
  ssq_pulse_state_t pstate_q;
  ssq_pulse_state_t pstate_d;
  logic [7:0] pcount_q;
  logic [3:0] phase_q;
  logic       level_q;
  logic       trig_q;
  logic       trig_rise_w;
  logic       phase_end_w;
  logic       burst_end_w;
  logic       start_w;

  assign trig_rise_w = ext_pulse_trigger_in & ~trig_q;
  assign phase_end_w = phase_q == SSQ_PULSE_HALF - 4'h1;
  // counted mode stops after the last high half
  assign burst_end_w = phase_end_w & level_q & ~pulse_mode_select_in
                       & (pcount_q == 8'h01); // RULE24
  assign start_w     = pulse_source_select_in ? trig_rise_w : 1'b1; // RULE20 RULE21

  always_comb begin
    pstate_d = pstate_q;
    case (pstate_q)
      SSQ_P_IDLE: begin
        if (pulse_release_in && !sync_busy_w && (pulse_count_value_in != SSQ_COUNT_ZERO
            || pulse_mode_select_in)) begin
          pstate_d = SSQ_P_ARM;
        end
      end
      SSQ_P_ARM: begin
        if (sync_busy_w) begin
          pstate_d = SSQ_P_IDLE;
        end else if (start_w) begin
          pstate_d = SSQ_P_RUN;
        end
      end
      SSQ_P_RUN: begin
        if (sync_busy_w || burst_end_w) begin
          pstate_d = SSQ_P_IDLE;
        end
      end
      default: pstate_d = SSQ_P_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pstate_q <= SSQ_P_IDLE;
      trig_q   <= 1'b0;
    end else begin
      pstate_q <= pstate_d;
      trig_q   <= ext_pulse_trigger_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pcount_q <= SSQ_COUNT_ZERO;
      phase_q  <= 4'h0;
      level_q  <= 1'b0;
    end else if (pstate_q != SSQ_P_RUN) begin
      pcount_q <= pulse_count_value_in;
      phase_q  <= 4'h0;
      level_q  <= 1'b0;
    end else if (phase_end_w) begin
      phase_q  <= 4'h0;
      level_q  <= ~level_q;
      if (level_q) begin
        pcount_q <= pcount_q - 8'h01;
      end
    end else begin
      phase_q  <= phase_q + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sysref_outputs_out <= 1'b0;  // RULE13
      sysref_active_out  <= 1'b0;
    end else begin
      // a sync strobe forces the level low in the same cycle as the busy flag
      sysref_outputs_out <= ((pstate_d == SSQ_P_RUN) & ~level_q & (pstate_q == SSQ_P_RUN)
                            & phase_end_w
                            | (pstate_d == SSQ_P_RUN) & level_q & ~phase_end_w)
                            & (sync_cnt_d == 4'h0); // RULE15
      sysref_active_out  <= pstate_d == SSQ_P_RUN;
    end
  end

  chk_irq_pin_follows: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE5
    (|(sticky_w & irq_enable_in)) |=> !irq_n_pin_out)
    else $error("interrupt pin not asserted");
  chk_irq_masked_off: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE4
    (irq_enable_in == SSQ_IRQ_EN_RST) |=> irq_n_pin_out)
    else $error("interrupt with all enables off");
  chk_lock_pin_both: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE11
    !second_pll_lock_in |=> !lock_pin_out)
    else $error("lock pin high without second pll lock");
  chk_lock_bypass: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE12
    (first_pll_bypass_in && second_pll_lock_in) |=> lock_pin_out)
    else $error("bypassed pll affected lock pin");
  chk_vco_pending: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
    vco_cal_done_in |=> !vco_cal_pending_out)
    else $error("calibration pending after done");

  sequence s_sync_start;
    div_sync_start_in;
  endsequence
  chk_sync_self_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE15
    s_sync_start ##1 !div_sync_start_in [*8] |=> !div_sync_busy_out)
    else $error("divider sync did not self-clear");
  chk_sync_outputs_low: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE15
    div_sync_busy_out |-> !clock_outputs_en_out && !sysref_outputs_out)
    else $error("outputs active during sync");
  chk_tune_release: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE17
    !vcxo_tune_hold_in |=> !vcxo_tune_mid_out)
    else $error("tune voltage not released");
  chk_det_mode: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE14
    (!first_pll_bypass_in && second_pll_fb_select_in) |=> deterministic_out)
    else $error("deterministic mode not flagged");
  chk_ext_waits_edge: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE21
    (pstate_q == SSQ_P_ARM && pulse_source_select_in && !trig_rise_w) |=> pstate_q != SSQ_P_RUN)
    else $error("pulse burst without trigger edge");
endmodule

// *** logic/ssq_pkg.sv ***
// constants for the status, interrupt and init sequencing block
package ssq_pkg;
  localparam int          SSQ_NUM_INPUTS   = 4;
  localparam int          SSQ_NUM_STICKY   = 8;
  // sticky vector bit positions
  localparam int          SSQ_BIT_IN0      = 0;
  localparam int          SSQ_BIT_PLL1     = 4;
  localparam int          SSQ_BIT_PLL2     = 5;
  localparam int          SSQ_BIT_HOLD     = 6;
  localparam int          SSQ_BIT_REF      = 7;
  // reset values
  localparam logic [7:0]  SSQ_STICKY_RST   = 8'h00;
  localparam logic [7:0]  SSQ_IRQ_EN_RST   = 8'h00;
  localparam logic [7:0]  SSQ_COUNT_ZERO   = 8'h00;
  // reference selection modes
  localparam logic [1:0]  SSQ_MODE_MANUAL  = 2'h0;
  localparam logic [1:0]  SSQ_MODE_SHORT   = 2'h1;
  localparam logic [1:0]  SSQ_MODE_AUTOHO  = 2'h2;
  localparam logic [1:0]  SSQ_MODE_AUTO    = 2'h3;
  // divider initialisation time
  localparam int          SSQ_CLK_MHZ      = 100;
  localparam int          SSQ_INIT_NS      = 80;
  localparam int          SSQ_INIT_CYC     = (SSQ_INIT_NS * SSQ_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  SSQ_INIT_CYC_W   = 4'(SSQ_INIT_CYC);
  // retrain pulse length
  localparam logic [3:0]  SSQ_RETRAIN_CYC  = 4'h4;
  // pulse generator half period in clocks
  localparam logic [3:0]  SSQ_PULSE_HALF   = 4'h2;

  typedef enum logic [1:0] {
    SSQ_P_IDLE = 2'b00,
    SSQ_P_ARM  = 2'b01,
    SSQ_P_RUN  = 2'b10
  } ssq_pulse_state_t;
endpackage

// *** logic/ssq_sticky_bit.sv ***
// one latched status bit with write-1 clear and interrupt gate
`timescale 1ns/1ps
module ssq_sticky_bit
  import ssq_pkg::*;
(
  input  wire logic clk_in,       // system clock
  input  wire logic rst_b_in,     // async reset, active low
  input  wire logic fault_in,     // fault present this cycle
  input  wire logic clear_in,     // write-1 clear strobe
  input  wire logic enable_in,    // interrupt enable
  output logic      sticky_out,   // latched bit
  output logic      irq_out       // gated request
);
  logic sticky_q;
  logic sticky_d;

  // set wins over clear, so a lasting fault re-sets at once
  assign sticky_d = fault_in | (sticky_q & ~clear_in); // RULE2 RULE3 RULE25

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sticky_q <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  assign sticky_out = sticky_q;
  assign irq_out    = sticky_q & enable_in; // RULE4

  chk_clear_needs_gone: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE3
    fault_in |=> sticky_q)
    else $error("sticky bit did not set on fault");
  chk_zero_no_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
    (sticky_q && !clear_in) |=> sticky_q)
    else $error("sticky bit dropped without clear");
  chk_clear_works: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
    (clear_in && !fault_in) |=> !sticky_q)
    else $error("sticky bit not cleared");
endmodule

// *** testbench/ssq_host_model.sv ***
// host-side model that issues control strobes in the required order
`timescale 1ns/1ps
module ssq_host_model
  import ssq_pkg::*;
(
  input  wire logic clk_in,       // system clock
  input  wire logic busy_in,      // divider sync running
  output logic      sync_out,     // divider sync strobe
  output logic      retrain_out,  // retrain strobe
  output logic      band_cal_out, // band cal strobe
  output logic      release_out,  // pulse release strobe
  output logic      tune_hold_out,// hold tune voltage
  output logic [7:0] clear_out,   // sticky write-1 clears
  output logic      out_en_out    // output enables
);
  initial begin
    {sync_out, retrain_out, band_cal_out, release_out} = 4'h0;
    clear_out = 8'h00;
    tune_hold_out = 1'b1;
    out_en_out = 1'b0;
  end

  // one-cycle strobe, order {sync, retrain, band cal, release}
  task automatic strobe(input logic [3:0] s, input logic [7:0] c);
    @(posedge clk_in);
    {sync_out, retrain_out, band_cal_out, release_out} <= s;
    clear_out <= c;
    @(posedge clk_in);
    {sync_out, retrain_out, band_cal_out, release_out} <= 4'h0;
    clear_out <= 8'h00;
  endtask

  task automatic wait_sync();
    @(negedge clk_in);
    for (int i = 0; i < 40 && busy_in; i++) begin
      @(negedge clk_in);
    end
  endtask

  // settings are already in place, then sync, retrain with band cal, tune release, clear
  task automatic init_seq();
    strobe(4'b1000, 8'h00);
    wait_sync();
    strobe(4'b0110, 8'h00);
    @(posedge clk_in);
    tune_hold_out <= 1'b0;
    strobe(4'b0000, 8'hff);
    @(posedge clk_in);
    out_en_out <= 1'b1;
  endtask
endmodule

// *** testbench/ssq_status_seq_test.sv ***
// randomized self-checking bench for the status and sequencing block
`timescale 1ns/1ps
module ssq_status_seq_test;
  import ssq_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] act = 4'hf;
  logic lk1 = 1'b1, lk2 = 1'b1, hold = 1'b0, cal = 1'b0, byp = 1'b0, fbs = 1'b1;
  logic [1:0] mode = 2'h0, sel = 2'h0;
  logic [7:0] ien = 8'hff, cnt = 8'h01, clr;
  logic src = 1'b0, cont = 1'b0, trig = 1'b0;
  logic sync, rtr, bcal, rel, tune, oen;
  logic [3:0] o_act;
  logic [1:0] o_sel;
  logic [7:0] o_st;
  logic o_lk1, o_lk2, o_nh, o_cal, o_ref, o_irq, o_lock, o_det;
  logic o_busy, o_rtr, o_bcal, o_mid, o_cen, o_sref, o_sact;
  logic [12:0] e_mom;
  logic [7:0] e_st, e_so;
  logic e_irq;
  int failures = 0, n_checks = 0, seed = 32'hdb676ac4, hi[4], rs[4];
  logic [31:0] r;

  always #5 clk_in = ~clk_in;

  ssq_host_model ssq_host_model_i (.clk_in(clk_in), .busy_in(o_busy), .sync_out(sync),
    .retrain_out(rtr), .band_cal_out(bcal), .release_out(rel), .tune_hold_out(tune),
    .clear_out(clr), .out_en_out(oen));

  ssq_status_seq ssq_status_seq_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .input_active_in(act), .first_pll_lock_in(lk1), .second_pll_lock_in(lk2),
    .holdover_in(hold), .vco_cal_done_in(cal), .ref_mode_in(mode), .selected_input_in(sel),
    .irq_enable_in(ien), .sticky_clear_in(clr), .first_pll_bypass_in(byp),
    .second_pll_fb_select_in(fbs), .div_sync_start_in(sync), .pll_retrain_in(rtr),
    .vco_band_cal_start_in(bcal), .vcxo_tune_hold_in(tune), .pulse_source_select_in(src),
    .pulse_mode_select_in(cont), .pulse_release_in(rel), .pulse_count_value_in(cnt),
    .ext_pulse_trigger_in(trig), .outputs_enable_in(oen), .input0_active_now_out(o_act),
    .first_pll_locked_now_out(o_lk1), .second_pll_locked_now_out(o_lk2),
    .not_holdover_now_out(o_nh), .vco_cal_pending_out(o_cal),
    .selected_input_report_out(o_sel), .reference_valid_now_out(o_ref), .sticky_out(o_st),
    .irq_n_pin_out(o_irq), .lock_pin_out(o_lock), .deterministic_out(o_det),
    .div_sync_busy_out(o_busy), .pll_retrain_out(o_rtr), .vco_band_cal_out(o_bcal),
    .vcxo_tune_mid_out(o_mid), .clock_outputs_en_out(o_cen), .sysref_outputs_out(o_sref),
    .sysref_active_out(o_sact));

  function automatic logic ref_ok(logic [3:0] a, logic [1:0] m, logic [1:0] s, logic h);
    if (m == SSQ_MODE_MANUAL || m == SSQ_MODE_SHORT) return a[s];
    if (m == SSQ_MODE_AUTOHO) return (|a) && !(h && !a[s]);
    return |a;
  endfunction

  wire logic rv = ref_ok(act, mode, sel, hold);
  wire logic [7:0] flt = {~rv, hold, ~lk2, ~lk1, ~act};
  wire logic [3:0] watch = {o_sref, o_bcal, o_rtr, o_busy};

  // reference model of status, sticky and interrupt behaviour
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      e_mom <= 13'h0020;
      e_st <= 8'h00;
      e_so <= 8'h00;
      e_irq <= 1'b1;
    end else begin
      e_mom <= {act, lk1, lk2, ~hold, ~cal, sel, rv, lk2 & (lk1 | byp), ~byp & fbs};
      e_st <= (e_st & ~clr) | flt;
      e_so <= e_st;
      e_irq <= ~|(e_st & ien);
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    check(16'(got), 16'(exp));
  endtask

  always @(negedge clk_in) begin
    if (rst_b_in) begin
      check(16'({o_act, o_lk1, o_lk2, o_nh, o_cal, o_sel, o_ref, o_lock, o_det}),
            16'(e_mom));
      check(16'(o_st), 16'(e_so));
      check(16'(o_irq), 16'(e_irq));
      if (o_busy) check(16'({o_cen, o_sref}), 16'h0);
    end
  end

  // counts high cycles and rising edges of each watched output
  task automatic measure(input int win);
    logic [3:0] p;
    p = 4'h0;
    hi = '{0, 0, 0, 0};
    rs = '{0, 0, 0, 0};
    repeat (win) begin
      @(negedge clk_in);
      for (int i = 0; i < 4; i++) begin
        hi[i] += int'(watch[i]);
        rs[i] += int'(watch[i] && !p[i]);
      end
      p = watch;
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    close_out();
  end

  initial begin
    int cnts[4] = '{0, 1, 3, 255};
    #12;
    check(16'({o_mid, o_cal, o_irq, o_cen, o_sref, o_st}), 16'h1c00);
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    lk1 <= 1'b0;
    @(posedge clk_in);
    lk1 <= 1'b1;
    ssq_host_model_i.strobe(4'b1000, 8'h00);
    measure(20);
    check_count(hi[0], SSQ_INIT_CYC);
    ssq_host_model_i.strobe(4'b0110, 8'h00);
    measure(12);
    check_count(hi[1], int'(SSQ_RETRAIN_CYC));
    check_count(hi[2], int'(SSQ_RETRAIN_CYC));
    ssq_host_model_i.strobe(4'b1000, 8'h00);
    ssq_host_model_i.strobe(4'b0100, 8'h00);
    measure(20);
    check_count(hi[1], 0);
    ssq_host_model_i.init_seq();
    repeat (3) @(posedge clk_in);
    #1 check(16'({o_mid, o_cen}), 16'h1);
    repeat (400) begin
      r = $random(seed);
      @(posedge clk_in);
      act <= (r[2:0] == 3'h0) ? r[7:4] : 4'hf;
      lk1 <= r[10:8] != 3'h0;
      lk2 <= r[13:11] != 3'h0;
      hold <= r[16:14] == 3'h0;
      cal <= r[17];
      mode <= r[19:18];
      sel <= r[21:20];
      ien <= r[22] ? 8'hff : r[31:24];
      byp <= r[23];
      fbs <= r[3];
      ssq_host_model_i.strobe(4'h0, r[31:24] ^ 8'h5a);
    end
    foreach (cnts[k]) begin
      cnt <= 8'(cnts[k]);
      ssq_host_model_i.strobe(4'b0001, 8'h00);
      measure(cnts[k] * 4 + 20);
      check_count(rs[3], cnts[k]);
    end
    measure(30);
    check_count(rs[3], 0);
    cont <= 1'b1;
    ssq_host_model_i.strobe(4'b0001, 8'h00);
    measure(60);
    check_count(int'(rs[3] >= 13), 1);
    check(16'(o_sact), 16'h1);
    ssq_host_model_i.strobe(4'b1000, 8'h00);
    measure(20);
    check(16'(o_sact), 16'h0);
    measure(30);
    check_count(rs[3], 0);
    cont <= 1'b0;
    src <= 1'b1;
    cnt <= 8'h02;
    ssq_host_model_i.strobe(4'b0001, 8'h00);
    measure(30);
    check_count(rs[3], 0);
    @(posedge clk_in);
    trig <= 1'b1;
    measure(40);
    check_count(rs[3], 2);
    @(posedge clk_in);
    trig <= 1'b0;
    @(posedge clk_in);
    trig <= 1'b1;
    measure(40);
    check_count(rs[3], 0);
    close_out();
  end
endmodule
